/* eear_eng_model.sv */
/* Serial-bus engine stand-in: EEPROM byte store and expander inputs.
   Assumes one request at a time from the register bank. */
module eear_eng_model
  import eear_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      srst,
  input  wire eear_req_t req,
  input  wire logic      start,
  output logic           ready,
  output eear_rsp_t      rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [int];
  logic [7:0] free;
  logic [3:0] wcnt;
  logic       act;
  eear_req_t  held;
  // Stalls one cycle in four so the bank must wait
  assign ready = !act && free[1:0] != 2'b00;
  always @(posedge clk) begin
    free <= free + 8'h01;
    // Answer lines toggle outside the done pulse
    rsp <= {1'b0, ~rsp.rdata, ~rsp.xp_in};
    if (srst) begin
      free <= 8'h00;
      act <= 1'b0;
      rsp <= '0;
    end else if (start) begin
      act <= 1'b1;
      held <= req;
      wcnt <= free[2] ? 4'h9 : 4'h1;
      if (req.eeprom && !req.read)
        mem[req.addr] = req.wdata;
    end else if (act && wcnt == 4'h0) begin
      act <= 1'b0;
      rsp <= {1'b1, mem.exists(held.addr) ? mem[held.addr] : 8'hff, 16'hc35a ^ 16'(held.xp_sel)};
    end else if (act) begin
      wcnt <= wcnt - 4'h1;
    end
  end
endmodule : eear_eng_model

/* eear_pkg.sv */
/*
  Package for the EEPROM and expander access register bank: offsets,
  field positions, reset values, states and carrier structs.
  Assumes a single core clock domain and a 32-bit APB register bus.
*/
package eear_pkg;

  localparam logic [11:0] EEAR_OFF_EEPROM   = 12'h42c;
  localparam logic [11:0] EEAR_OFF_EXPANDER = 12'h430;
  localparam logic [11:0] EEAR_OFF_IRQ_STAT = 12'h440;
  localparam logic [11:0] EEAR_OFF_IRQ_MASK = 12'h444;

  // eeprom_access_control fields
  localparam int EE_ADDR_LSB = 0;
  localparam int EE_DATA_LSB = 16;
  localparam int EE_BUSY_BIT = 24;
  localparam int EE_DONE_BIT = 25;
  localparam int EE_OP_BIT   = 26;

  // expander_access_control fields
  localparam int XP_PINS_LSB = 0;
  localparam int XP_REFR_BIT = 24;
  localparam int XP_TM_BIT   = 25;
  localparam int XP_SEL_LSB  = 26;
  localparam int XP_DONE_BIT = 31;

  // Interrupt status bits
  localparam int IRQ_EE_BIT = 0;
  localparam int IRQ_XP_BIT = 1;

  localparam logic [31:0] EEAR_RESET_VAL  = 32'h0000_0000;
  localparam logic [3:0]  XP_SEL_MAX      = 4'h4;
  localparam int          XP_COUNT        = 5;
  localparam logic        EE_OP_WRITE     = 1'b0;
  localparam logic        EE_OP_READ      = 1'b1;

  typedef enum logic [1:0] {
    EEAR_IDLE = 2'b00,
    EEAR_REQ  = 2'b01,
    EEAR_WAIT = 2'b11
  } eear_state_t;

  // Request to the serial-bus engine
  typedef struct packed {
    logic        eeprom;
    logic        read;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [2:0]  xp_sel;
    logic [15:0] xp_out;
  } eear_req_t;

  // Answer from the serial-bus engine
  typedef struct packed {
    logic        done;
    logic [7:0]  rdata;
    logic [15:0] xp_in;
  } eear_rsp_t;

endpackage : eear_pkg

/* eear_regs.sv */
/*
  EEPROM and I/O expander access register bank behind an APB slave.
  Hands single operations to an external serial-bus engine and keeps
  a pin image per expander. Assumes one clock and synchronous reset.
*/
module eear_regs
  import eear_pkg::*;
#(
  parameter int XP_PINS = 16
) (
  input  wire logic               CLK_SYS,
  input  wire logic               SRST,
  input  wire logic               CE,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [11:0]        PADDR,
  input  wire logic [31:0]        PWDATA,
  input  wire logic [3:0]         PSTRB,
  output logic      [31:0]        PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  output logic                    IRQ,
  // Serial-bus engine side
  output eear_req_t               ENG_REQ,
  output logic                    ENG_START,
  input  wire logic               ENG_READY,
  input  wire eear_rsp_t          ENG_RSP,
  // Core logic side of the expanders
  input  wire logic [XP_PINS-1:0] CORE_XP_OUT [XP_COUNT],
  input  wire logic [XP_PINS-1:0] XP_DIR_IN   [XP_COUNT],
  output logic      [XP_PINS-1:0] XP_PINS_IN  [XP_COUNT]
);

  function automatic logic byte_en(input logic [3:0] strb, input int bit_idx);
    byte_en = strb[bit_idx / 8];
  endfunction : byte_en

  logic [15:0]        ee_addr;
  logic [7:0]         ee_data;
  logic               ee_op;
  logic               ee_done;
  logic               xp_tm;
  logic [3:0]         xp_sel;
  logic               xp_done;
  logic [XP_PINS-1:0] xp_sw   [XP_COUNT];
  logic [XP_PINS-1:0] xp_img  [XP_COUNT];
  logic [1:0]         irq_mask;
  logic               op_is_ee;
  logic [2:0]         op_sel;
  logic               op_read;
  logic [31:0]        rdata;

  // Bus decode
  wire wr_en     = PSEL && PENABLE && PWRITE;
  // Read word captured in setup so it stands at the access edge
  wire rd_setup  = PSEL && !PENABLE && !PWRITE;
  wire hit_ee    = (PADDR == EEAR_OFF_EEPROM);
  wire hit_xp    = (PADDR == EEAR_OFF_EXPANDER);
  wire hit_st    = (PADDR == EEAR_OFF_IRQ_STAT);
  wire hit_mk    = (PADDR == EEAR_OFF_IRQ_MASK);
  wire hit_any   = hit_ee || hit_xp || hit_st || hit_mk;
  wire wr_ee     = wr_en && hit_ee;
  wire wr_xp     = wr_en && hit_xp;
  wire wr_st     = wr_en && hit_st;
  wire wr_mk     = wr_en && hit_mk;
  wire sel_ok    = (xp_sel <= XP_SEL_MAX);
  wire [2:0] sel = sel_ok ? xp_sel[2:0] : 3'h0;

  wire ee_busy;
  wire seq_launch;
  wire seq_finish;
  wire ee_start  = wr_ee && byte_en(PSTRB, EE_DATA_LSB) && !ee_busy;
  wire refr_req  = wr_xp && byte_en(PSTRB, XP_REFR_BIT) && PWDATA[XP_REFR_BIT]
                   && sel_ok;
  wire xp_start  = refr_req && !ee_busy && !ee_start;
  wire ee_finish = seq_finish && op_is_ee;
  wire xp_finish = seq_finish && !op_is_ee;

  // A refresh while an EEPROM operation runs is dropped; one engine, no queue.
  eear_seq u_seq (
    .clk       (CLK_SYS),
    .srst      (SRST),
    .ce        (CE),
    .start     (ee_start || xp_start),
    .eng_ready (ENG_READY),
    .eng_done  (ENG_RSP.done),
    .launch    (seq_launch),
    .busy      (ee_busy),
    .finish    (seq_finish)
  );

  // Outputs toward the expander come from core unless test mode is on
  function automatic logic [XP_PINS-1:0] out_val(input logic tm, input logic [XP_PINS-1:0] sw,
                                                 input logic [XP_PINS-1:0] core,
                                                 input logic [XP_PINS-1:0] dir_in);
    out_val = (tm ? sw : core) & ~dir_in;
  endfunction : out_val

  assign ENG_START      = seq_launch;
  assign ENG_REQ.eeprom = op_is_ee;
  assign ENG_REQ.read   = op_read;
  assign ENG_REQ.addr   = ee_addr;
  assign ENG_REQ.wdata  = ee_data;
  assign ENG_REQ.xp_sel = op_sel;
  assign ENG_REQ.xp_out = out_val(xp_tm, xp_sw[op_sel], CORE_XP_OUT[op_sel], XP_DIR_IN[op_sel]);

  // Register read mux
  wire [31:0] ee_word = {5'h00, ee_op, ee_done, ee_busy, ee_data, ee_addr};
  wire [31:0] xp_word = {xp_done, 1'b0, xp_sel, xp_tm, 1'b0, 8'h00,
                         xp_img[sel]};
  wire [31:0] st_word = {30'h0, xp_done, ee_done};
  wire [31:0] mk_word = {30'h0, irq_mask};

  always_comb begin
    rdata = 32'h0000_0000;
    if (hit_ee) rdata = ee_word;
    if (hit_xp) rdata = xp_word;
    if (hit_st) rdata = st_word;
    if (hit_mk) rdata = mk_word;
  end

  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit_any;
  assign IRQ     = |({xp_done, ee_done} & irq_mask);

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      PRDATA <= EEAR_RESET_VAL;
    end else if (CE && rd_setup) begin
      PRDATA <= rdata;
    end
  end

  // EEPROM access register
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      ee_addr <= EEAR_RESET_VAL[15:0];
      ee_data <= EEAR_RESET_VAL[23:16];
      ee_op   <= EEAR_RESET_VAL[EE_OP_BIT];
    end else if (CE) begin
      if (wr_ee && !ee_busy) begin
        if (byte_en(PSTRB, EE_ADDR_LSB)) ee_addr[7:0]  <= PWDATA[7:0];
        if (byte_en(PSTRB, 8))           ee_addr[15:8] <= PWDATA[15:8];
        if (byte_en(PSTRB, EE_OP_BIT))   ee_op         <= PWDATA[EE_OP_BIT];
        // Read operation ignores the launching data byte
        if (byte_en(PSTRB, EE_DATA_LSB) &&
            !(byte_en(PSTRB, EE_OP_BIT) ? PWDATA[EE_OP_BIT] : ee_op))
          ee_data <= PWDATA[23:16];
      end
      if (ee_finish && op_read) ee_data <= ENG_RSP.rdata;
    end
  end

  // Operation latched at start so later register writes cannot disturb it
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      op_is_ee <= 1'b0;
      op_read  <= 1'b0;
      op_sel   <= 3'h0;
    end else if (CE && (ee_start || xp_start)) begin
      op_is_ee <= ee_start;
      op_read  <= ee_start && (byte_en(PSTRB, EE_OP_BIT) ? PWDATA[EE_OP_BIT] : ee_op);
      op_sel   <= sel;
    end
  end

  // Sticky completion flags; a set in the clearing cycle wins
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      ee_done  <= 1'b0;
      xp_done  <= 1'b0;
      irq_mask <= 2'b00;
    end else if (CE) begin
      ee_done <= ee_finish ||
                 (ee_done && !((wr_ee && byte_en(PSTRB, EE_DONE_BIT) && PWDATA[EE_DONE_BIT]) ||
                               (wr_st && byte_en(PSTRB, 0) && PWDATA[IRQ_EE_BIT])));
      xp_done <= xp_finish ||
                 (xp_done && !((wr_xp && byte_en(PSTRB, XP_DONE_BIT) && PWDATA[XP_DONE_BIT]) ||
                               (wr_st && byte_en(PSTRB, 0) && PWDATA[IRQ_XP_BIT])));
      if (wr_mk && byte_en(PSTRB, 0)) irq_mask <= PWDATA[1:0];
    end
  end

  // Expander control: test mode, selector
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      xp_tm  <= 1'b0;
      xp_sel <= 4'h0;
    end else if (CE && wr_xp) begin
      if (byte_en(PSTRB, XP_TM_BIT))  xp_tm  <= PWDATA[XP_TM_BIT];
      if (byte_en(PSTRB, XP_SEL_LSB)) xp_sel <= PWDATA[XP_SEL_LSB +: 4];
    end
  end

  // Per-expander software values and pin images
  genvar g;
  generate
    for (g = 0; g < XP_COUNT; g++) begin : g_xp
      wire sw_wr  = CE && wr_xp && xp_tm && sel_ok && (sel == 3'(g));
      wire upd    = CE && xp_finish && (op_sel == 3'(g));
      wire [XP_PINS-1:0] be = {{8{byte_en(PSTRB, 8)}}, {8{byte_en(PSTRB, 0)}}};
      always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
          xp_sw[g]  <= '0;
          xp_img[g] <= '0;
        end else begin
          if (sw_wr) begin
            xp_sw[g] <= (xp_sw[g] & ~(be & ~XP_DIR_IN[g])) |
                        (PWDATA[XP_PINS-1:0] & be & ~XP_DIR_IN[g]);
          end
          if (upd) begin
            xp_img[g] <= (ENG_RSP.xp_in & XP_DIR_IN[g]) |
                         (out_val(xp_tm, xp_sw[g], CORE_XP_OUT[g], XP_DIR_IN[g]));
          end
        end
      end
      assign XP_PINS_IN[g] = xp_img[g] & XP_DIR_IN[g];
    end
  endgenerate

endmodule : eear_regs

/* eear_regs_sva.sv */
/* Port checker for eear_regs.
   Assumes the engine answers each start with one done pulse. */
module eear_regs_sva
  import eear_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        SRST,
  input wire logic        CE,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0]  PSTRB,
  input wire logic [31:0] PRDATA,
  input wire eear_req_t   ENG_REQ,
  input wire logic        ENG_START,
  input wire eear_rsp_t   ENG_RSP
);
  logic        busy;
  logic [15:0] addr;
  logic [3:0]  sel;
  wire acc = PSEL && PENABLE && CE;
  wire rd_ee = acc && !PWRITE && PADDR == EEAR_OFF_EEPROM;
  wire rd_xp = acc && !PWRITE && PADDR == EEAR_OFF_EXPANDER;
  wire ee_wr = acc && PWRITE && PADDR == EEAR_OFF_EEPROM && !busy;
  wire go = ee_wr && PSTRB[2];
  wire xp_wr = acc && PWRITE && PADDR == EEAR_OFF_EXPANDER;
  wire xrf = xp_wr && PSTRB[3] && PWDATA[XP_REFR_BIT] && !busy;
  // Refresh acts on the selector already held, not the one in the same write
  wire refr = xrf && sel <= XP_SEL_MAX;
  // EEPROM address, data and op writes during an operation are dropped (a done clear still acts), so the address shadow ignores them too
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      busy <= 1'b0;
      addr <= '0;
      sel <= '0;
    end else if (CE) begin
      busy <= (go || refr) ? 1'b1 : (ENG_RSP.done ? 1'b0 : busy);
      addr[7:0] <= (ee_wr && PSTRB[0]) ? PWDATA[7:0] : addr[7:0];
      addr[15:8] <= (ee_wr && PSTRB[1]) ? PWDATA[15:8] : addr[15:8];
      sel <= (xp_wr && PSTRB[3]) ? PWDATA[XP_SEL_LSB +: 4] : sel;
    end
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  launch_follows_a: assert property (go |-> ##[1:30] ENG_START)
    else $error("no engine start after data write");
  single_start_a: assert property (ENG_START |=> !ENG_START)
    else $error("second start while busy");
  start_addr_a: assert property (ENG_START && ENG_REQ.eeprom |-> ENG_REQ.addr == addr)
    else $error("eeprom start with wrong address");
  write_byte_a: assert property (go && PSTRB[3] && !PWDATA[EE_OP_BIT] |=>
    ENG_REQ.eeprom && !ENG_REQ.read && ENG_REQ.wdata == $past(PWDATA[23:16])) else $error("bad write byte");
  read_select_a: assert property (go && PSTRB[3] && PWDATA[EE_OP_BIT] |=> ENG_REQ.read)
    else $error("read op not selected");
  rsv_zero_a: assert property (rd_ee |-> PRDATA[31:27] == 5'h00)
    else $error("reserved bits not zero");
  refresh_zero_a: assert property (rd_xp |-> PRDATA[24:16] == 9'h000)
    else $error("refresh bit reads one");
  sel_reserved_a: assert property (xrf && sel > XP_SEL_MAX |=> !ENG_START [*4])
    else $error("refresh to reserved select");
  cover property (go && PWDATA[EE_OP_BIT]);
  cover property (go && !PWDATA[EE_OP_BIT]);
  cover property (refr && PWDATA[XP_TM_BIT]);
endmodule : eear_regs_sva
bind eear_regs eear_regs_sva u_sva (.CLK_SYS, .SRST, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB,
  .PRDATA, .ENG_REQ, .ENG_START, .ENG_RSP);

/* eear_seq.sv */
/*
  Operation sequencer: one request at a time to the serial-bus engine,
  busy while outstanding, single-cycle finish pulse.
  Assumes the engine answers each accepted start with one done pulse.
*/
module eear_seq
  import eear_pkg::*;
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic start,
  input  wire logic eng_ready,
  input  wire logic eng_done,
  output logic      launch,
  output logic      busy,
  output logic      finish
);

  eear_state_t state;
  eear_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      EEAR_IDLE: if (start) next_state = EEAR_REQ;
      EEAR_REQ:  if (eng_ready) next_state = EEAR_WAIT;
      EEAR_WAIT: if (eng_done) next_state = EEAR_IDLE;
      default:   next_state = EEAR_IDLE;
    endcase
  end

  assign launch = (state == EEAR_REQ) && eng_ready;
  assign busy   = (state != EEAR_IDLE);
  assign finish = (state == EEAR_WAIT) && eng_done;

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= EEAR_IDLE;
    end else if (ce) begin
      state <= next_state;
    end
  end

endmodule : eear_seq

/* tb_eeprom_and_expander_access_regs.sv */
/* Self-checking bench for eear_regs with the engine model.
   Assumes the APB slave answers in time and one engine request at a time. */
module tb_eeprom_and_expander_access_regs
  import eear_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, srst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, rdv;
  logic [3:0]  pstrb = '0;
  logic [15:0] core [XP_COUNT], dir [XP_COUNT], pins [XP_COUNT], img [XP_COUNT], a, x;
  logic [7:0]  dt, ref_mem [int];
  wire  [31:0] prdata;
  wire         pready, pslverr, irq, start, ready;
  eear_req_t   req;
  eear_rsp_t   rsp;
  int          errors = 0, compares = 0, cyc = 0, seed = 66;
  eear_regs DUT (.CLK_SYS(clk), .SRST(srst), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .IRQ(irq), .ENG_REQ(req), .ENG_START(start), .ENG_READY(ready), .ENG_RSP(rsp), .CORE_XP_OUT(core),
    .XP_DIR_IN(dir), .XP_PINS_IN(pins));
  eear_eng_model u_eng (.clk(clk), .srst(srst), .req(req), .start(start), .ready(ready), .rsp(rsp));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      $display("ERROR %0t timeout", $time);
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, ad, d, s};
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    e = pslverr;
    // Read data was loaded at the setup edge and stands at this one
    rdv = prdata;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic wait_bit(input logic [11:0] ad, input int b, input logic v);
    do
      apb(1'b0, ad, '0, '0);
    while (rdv[b] !== v);
  endtask : wait_bit
  function automatic logic [31:0] xw(input int k, input logic tm, input logic rf, input logic [15:0] d);
    return {2'b00, 4'(k), tm, rf, 8'h00, d};
  endfunction : xw
  initial begin
    for (int k = 0; k < XP_COUNT; k++) begin
      core[k] = 16'($random(seed));
      dir[k] = 16'($random(seed));
      img[k] = 16'h0000;
    end
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, EEAR_OFF_EEPROM, '0, '0);
    chk(rdv, EEAR_RESET_VAL);
    apb(1'b0, 12'h400, '0, '0);
    chk({rdv[30:0], e}, 32'h1);
    // Access while frozen is dropped
    a = 16'($random(seed));
    ce <= 1'b0;
    apb(1'b1, EEAR_OFF_EEPROM, 32'(a), 4'h3);
    ce <= 1'b1;
    apb(1'b0, EEAR_OFF_EEPROM, '0, '0);
    chk(rdv, EEAR_RESET_VAL);
    $display("test reset finished");
    for (int i = 0; i < 4; i++) begin
      a = 16'($random(seed));
      dt = 8'($random(seed));
      ref_mem[a] = dt;
      apb(1'b1, EEAR_OFF_IRQ_MASK, 32'(i % 2), 4'hf);
      apb(1'b1, EEAR_OFF_EEPROM, {5'h00, EE_OP_WRITE, 2'b00, dt, a}, 4'hf);
      apb(1'b1, EEAR_OFF_EEPROM, {16'h0000, ~a}, 4'h3);
      wait_bit(EEAR_OFF_EEPROM, EE_BUSY_BIT, 1'b0);
      chk({irq, rdv[30:0]}, {i[0], 7'h02, dt, a});
      apb(1'b1, EEAR_OFF_IRQ_STAT, 32'h1, 4'hf);
      apb(1'b1, EEAR_OFF_EEPROM, 32'h0200_0000, 4'h8);
      apb(1'b0, EEAR_OFF_EEPROM, '0, '0);
      chk({irq, rdv[30:0]}, {8'h00, dt, a});
      apb(1'b1, EEAR_OFF_EEPROM, {5'h00, EE_OP_READ, 2'b00, ~dt, a}, 4'hf);
      apb(1'b0, EEAR_OFF_EEPROM, '0, '0);
      chk(32'(rdv[EE_BUSY_BIT]), 32'h1);
      wait_bit(EEAR_OFF_EEPROM, EE_BUSY_BIT, 1'b0);
      chk(rdv, {8'h06, ref_mem[a], a});
      apb(1'b1, EEAR_OFF_IRQ_STAT, 32'h1, 4'hf);
      apb(1'b1, EEAR_OFF_EEPROM, 32'h0200_0000, 4'h8);
    end
    $display("test eeprom finished");
    for (int k = 0; k <= XP_COUNT; k++) begin
      x = 16'hc35a ^ 16'(k);
      apb(1'b1, EEAR_OFF_EXPANDER, xw(k, 1'b0, 1'b0, ~x), 4'hf);
      apb(1'b0, EEAR_OFF_EXPANDER, '0, '0);
      chk(rdv, xw(k, 1'b0, 1'b0, img[k % XP_COUNT]));
      for (int t = 0; t < (k < XP_COUNT ? 2 : 1); t++) begin
        // Test mode must already be on for the pin bits to take the write
        apb(1'b1, EEAR_OFF_EXPANDER, xw(k, t[0], 1'b0, ~x), 4'hf);
        apb(1'b1, EEAR_OFF_EXPANDER, xw(k, t[0], 1'b1, ~x), 4'hf);
        if (k < XP_COUNT) begin
          wait_bit(EEAR_OFF_EXPANDER, XP_DONE_BIT, 1'b1);
          img[k] = (dir[k] & x) | (~dir[k] & (t[0] ? ~x : core[k]));
          chk(rdv, 32'h8000_0000 | xw(k, t[0], 1'b0, img[k]));
          chk(32'(pins[k]), 32'(dir[k] & x));
          apb(1'b1, EEAR_OFF_EXPANDER, 32'h8000_0000 | xw(k, 1'b0, 1'b0, 16'h0000), 4'h8);
        end else begin
          repeat (20) @(posedge clk);
          apb(1'b0, EEAR_OFF_EXPANDER, '0, '0);
          chk(rdv, xw(k, 1'b0, 1'b0, img[0]));
        end
      end
    end
    $display("test expander finished");
    end_of_test();
  end
endmodule : tb_eeprom_and_expander_access_regs
